// File: rtl/pio_host.sv
`timescale 1ns/1ps
`default_nettype none
module pio_host (
  clk,
  arst_n,
  req_valid,
  req_ready,
  req_write,
  req_cs,
  req_addr,
  req_reg8,
  req_wdata,
  pio_mode,
  rsp_valid,
  rsp_rdata,
  rsp_wide,
  rsp_waited,
  cs_n,
  addr,
  iord_n,
  iowr_n,
  data_o,
  data_oe,
  data_i,
  iordy,
  iocs16_n
);
  import pio_host_pkg::*;
  input wire logic clk;
  input wire logic arst_n;
  input wire logic req_valid;
  output logic req_ready;
  input wire logic req_write;
  input wire logic [1:0] req_cs;
  input wire logic [2:0] req_addr;
  input wire logic req_reg8;
  input wire logic [15:0] req_wdata;
  input wire pio_host_pkg::mode_t pio_mode;
  output logic rsp_valid;
  output logic [15:0] rsp_rdata;
  output logic rsp_wide;
  output logic rsp_waited;
  output logic [1:0] cs_n;
  output logic [2:0] addr;
  output logic iord_n;
  output logic iowr_n;
  output logic [15:0] data_o;
  output logic data_oe;
  input wire logic [15:0] data_i;
  input wire logic iordy;
  input wire logic iocs16_n;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [17:0] pins_s;
  logic rdy_s;
  logic cs16_s;
  logic [15:0] din_s;

  pio_sync3 #(.W(18)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_i({iordy, ~iocs16_n, data_i}),
    .sync_o(pins_s)
  );
  assign rdy_s = pins_s[17];
  assign cs16_s = pins_s[16];
  assign din_s = pins_s[15:0];

  // ------------------------------------------------------------
  // per-mode interval selection
  // ------------------------------------------------------------
  mode_t mode_q;
  mode_t mode_d;
  logic reg8_q;
  logic reg8_d;
  cnt_t c_cycle;
  cnt_t c_act;
  cnt_t c_rec;
  cnt_t c_setup;
  cnt_t c_hold;
  int mi;

  always_comb begin
    mi = (int'(mode_q) < NUM_MODES) ? int'(mode_q) : 0;
    c_cycle = ns_to_cyc(T0_NS[mi]);
    c_act = reg8_q ? ns_to_cyc(T2R_NS[mi]) : ns_to_cyc(T2_NS[mi]);
    c_rec = ns_to_cyc(T2I_NS[mi]);
    c_setup = ns_to_cyc(T1_NS[mi]);
    c_hold = ns_to_cyc(T9_NS[mi]);
    // bus turnaround after a read also needs the card to float the bus
    if (c_hold < T6Z_CYC) begin
      c_hold = T6Z_CYC;
    end
  end

  // ------------------------------------------------------------
  // cycle sequencer
  // ------------------------------------------------------------
  state_e st_q;
  state_e st_d;
  cnt_t tmr_q;
  cnt_t tmr_d;
  cnt_t tot_q;
  cnt_t tot_d;
  logic wr_q;
  logic wr_d;
  logic waited_q;
  logic waited_d;
  logic wide_q;
  logic wide_d;
  logic [15:0] rd_q;
  logic [15:0] rd_d;
  logic [1:0] cs_n_q;
  logic [1:0] cs_n_d;
  logic [2:0] addr_q;
  logic [2:0] addr_d;
  logic [15:0] wdat_q;
  logic [15:0] wdat_d;
  logic oe_q;
  logic oe_d;
  logic rd_n_q;
  logic rd_n_d;
  logic wr_n_q;
  logic wr_n_d;
  logic rdy_q;
  logic rdy_d;
  logic vld_q;
  logic vld_d;
  logic act_done;

  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q + cnt_t'(1);
    tot_d = (tot_q == '1) ? tot_q : tot_q + cnt_t'(1);
    mode_d = mode_q;
    reg8_d = reg8_q;
    wr_d = wr_q;
    waited_d = waited_q;
    wide_d = wide_q;
    rd_d = rd_q;
    cs_n_d = cs_n_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    oe_d = oe_q;
    rd_n_d = rd_n_q;
    wr_n_d = wr_n_q;
    rdy_d = 1'b0;
    vld_d = 1'b0;
    // strobe may end only after its least width and after ready returns
    act_done = (tmr_q >= c_act - cnt_t'(1));
    unique case (st_q)
      ST_IDLE: begin
        rdy_d = 1'b1;
        if (req_valid && rdy_q) begin
          rdy_d = 1'b0;
          mode_d = (int'(pio_mode) < NUM_MODES) ? pio_mode : mode_t'(0);
          reg8_d = req_reg8;
          wr_d = req_write;
          cs_n_d = ~req_cs;
          addr_d = req_addr;
          wdat_d = req_wdata;
          oe_d = req_write;
          waited_d = 1'b0;
          wide_d = 1'b0;
          tmr_d = '0;
          tot_d = '0;
          st_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tmr_q >= c_setup - cnt_t'(1)) begin
          rd_n_d = wr_q;
          wr_n_d = ~wr_q;
          tmr_d = '0;
          st_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        // 16-bit flag means nothing in the faster modes
        if (mode_q < MODE_NO_IOCS16 && cs16_s) begin
          wide_d = 1'b1;
        end
        if (tmr_q == TA_SMP_CYC && !rdy_s) begin
          waited_d = 1'b1;
          st_d = ST_WAIT;
        end else if (act_done && tmr_q > TA_SMP_CYC) begin
          // read data captured as strobe ends
          rd_d = din_s;
          rd_n_d = 1'b1;
          wr_n_d = 1'b1;
          tmr_d = '0;
          st_d = ST_HOLD;
        end
      end
      ST_WAIT: begin
        if (rdy_s && act_done) begin
          rd_d = din_s;
          rd_n_d = 1'b1;
          wr_n_d = 1'b1;
          tmr_d = '0;
          st_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tmr_q >= c_hold - cnt_t'(1)) begin
          oe_d = 1'b0;
          cs_n_d = 2'b11;
          tmr_d = '0;
          st_d = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // recovery stretched until whole cycle time is met
        if (tmr_q >= c_rec && tot_q >= c_cycle) begin
          vld_d = 1'b1;
          rdy_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      tmr_q <= '0;
      tot_q <= '0;
      mode_q <= '0;
      reg8_q <= 1'b0;
      wr_q <= 1'b0;
      waited_q <= 1'b0;
      wide_q <= 1'b0;
      rd_q <= '0;
      cs_n_q <= 2'b11;
      addr_q <= '0;
      wdat_q <= '0;
      oe_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      rdy_q <= 1'b0;
      vld_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      tot_q <= tot_d;
      mode_q <= mode_d;
      reg8_q <= reg8_d;
      wr_q <= wr_d;
      waited_q <= waited_d;
      wide_q <= wide_d;
      rd_q <= rd_d;
      cs_n_q <= cs_n_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      oe_q <= oe_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      rdy_q <= rdy_d;
      vld_q <= vld_d;
    end
  end

  assign req_ready = rdy_q;
  assign rsp_valid = vld_q;
  assign rsp_rdata = rd_q;
  assign rsp_wide = wide_q;
  assign rsp_waited = waited_q;
  assign cs_n = cs_n_q;
  assign addr = addr_q;
  assign iord_n = rd_n_q;
  assign iowr_n = wr_n_q;
  assign data_o = wdat_q;
  assign data_oe = oe_q;
endmodule : pio_host
`default_nettype wire

// File: rtl/pio_host_pkg.sv
package pio_host_pkg;
  // ------------------------------------------------------------
  // clock and mode table
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int NUM_MODES = 5;
  localparam int CNT_W = 8;
  localparam int MODE_W = 3;
  typedef logic [CNT_W-1:0] cnt_t;
  typedef logic [MODE_W-1:0] mode_t;

  // minimum cycle, active, 8-bit register active, recovery, setup and hold times (ns)
  localparam int T0_NS [NUM_MODES] = '{600, 383, 240, 180, 120};
  localparam int T2_NS [NUM_MODES] = '{165, 125, 100, 80, 70};
  localparam int T2R_NS [NUM_MODES] = '{290, 290, 290, 80, 70};
  localparam int T2I_NS [NUM_MODES] = '{0, 0, 0, 70, 25};
  localparam int T1_NS [NUM_MODES] = '{70, 50, 30, 30, 25};
  localparam int T9_NS [NUM_MODES] = '{20, 15, 10, 10, 10};
  localparam int TA_NS = 35;
  localparam int T6Z_NS = 30;
  // first mode in which the 16-bit indication is not valid
  localparam logic [MODE_W-1:0] MODE_NO_IOCS16 = 3'h3;

  // least times round up to whole cycles, never below one
  function automatic cnt_t ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return cnt_t'(c);
  endfunction

  localparam cnt_t TA_CYC = ns_to_cyc(TA_NS);
  localparam cnt_t T6Z_CYC = ns_to_cyc(T6Z_NS);
  // pin synchroniser delay; ready is judged on samples past the setup time
  localparam cnt_t PIN_LAT_CYC = 8'h03;
  localparam cnt_t TA_SMP_CYC = cnt_t'(TA_CYC + PIN_LAT_CYC);

  // ------------------------------------------------------------
  // host cycle states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_WAIT = 3'b011,
    ST_HOLD = 3'b100,
    ST_RECOVER = 3'b101
  } state_e;
endpackage : pio_host_pkg

// File: rtl/pio_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module pio_sync3 #(
  parameter int W = 1
) (
  clk,
  arst_n,
  async_i,
  sync_o
);
  input wire logic clk;
  input wire logic arst_n;
  input wire logic [W-1:0] async_i;
  output logic [W-1:0] sync_o;

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // ------------------------------------------------------------
  // accept a change once stages two and three agree
  // ------------------------------------------------------------
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_o = out_q;
endmodule : pio_sync3
`default_nettype wire

// File: test/pio_host_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pio_host_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_reg8,
  input wire pio_host_pkg::mode_t pio_mode,
  input wire logic rsp_valid,
  input wire logic rsp_wide,
  input wire logic [1:0] cs_n,
  input wire logic [2:0] addr,
  input wire logic iord_n,
  input wire logic iowr_n,
  input wire logic [15:0] data_o,
  input wire logic data_oe,
  input wire logic iordy
);
  import pio_host_pkg::*;
  // ----
  // strobe counters
  // ----
  logic off;
  logic r8_q;
  mode_t m_q;
  int act_q, ina_q, cyc_q, mi, mn;
  assign off = iord_n & iowr_n;
  always_comb begin
    mi = (m_q > 3'h4) ? 0 : int'(m_q);
    mn = r8_q ? T2R_NS[mi] : T2_NS[mi];
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      m_q <= '0;
      r8_q <= 1'b0;
      act_q <= 0;
      ina_q <= 999;
      cyc_q <= 999;
    end else begin
      if (req_valid && req_ready) begin
        m_q <= pio_mode;
        r8_q <= req_reg8;
      end
      act_q <= off ? 0 : act_q + 1;
      ina_q <= off ? ina_q + 1 : 0;
      cyc_q <= (!off && act_q == 0) ? 1 : cyc_q + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_fall; $fell(off); endsequence
  sequence s_stall; (!off && !iordy) [*8]; endsequence
  property p_setup;
    s_fall |-> $past(addr, 3) == addr && $past(cs_n, 3) == cs_n;
  endproperty
  a_setup: assert property (p_setup) else $error("setup");
  property p_hold; $rose(off) |=> ($stable(addr) && $stable(cs_n)) [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_active; $rose(off) |-> act_q >= (mn + 7) / 8; endproperty
  a_active: assert property (p_active) else $error("width");
  property p_cycle; s_fall |-> cyc_q >= (T0_NS[mi] + 7) / 8; endproperty
  a_cycle: assert property (p_cycle) else $error("cycle");
  property p_recov; s_fall |-> ina_q >= (T2I_NS[mi] + 7) / 8; endproperty
  a_recov: assert property (p_recov) else $error("recovery");
  property p_wait; s_stall |=> !off; endproperty
  a_wait: assert property (p_wait) else $error("wait");
  property p_end; !off && $rose(iordy) |-> ##[1:44] off; endproperty
  a_end: assert property (p_end) else $error("end");
  property p_wide; rsp_valid |-> rsp_wide == (mi < 3); endproperty
  a_wide: assert property (p_wide) else $error("wide");
  property p_bus; !iowr_n |-> data_oe && $stable(data_o); endproperty
  a_bus: assert property (p_bus) else $error("bus");
endmodule // pio_host_checker
bind pio_host pio_host_checker pio_host_checker_i (.*);
`default_nettype wire

// File: test/pio_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module pio_card_model (
  input wire logic clk,
  input wire logic [1:0] cs_n,
  input wire logic [2:0] addr,
  input wire logic iord_n,
  input wire logic iowr_n,
  input wire logic [15:0] data_o,
  input wire logic [7:0] wt,
  output logic [15:0] data_i,
  output logic iordy,
  output logic iocs16_n
);
  // ----
  // card side
  // ----
  logic [15:0] mem [32];
  logic [15:0] last = '0;
  logic low = 1'b0;
  int n = 0;
  assign iocs16_n = (cs_n == 2'h3);
  // released bus shows the inverse of the last value
  assign data_i = !iord_n ? mem[{cs_n, addr}] : ~last;
  assign iordy = !low;
  always @(posedge clk) begin
    if (!iord_n) last <= data_i;
    if (!iowr_n) mem[{cs_n, addr}] <= data_o;
    if (cs_n == 2'h3) begin
      n <= 0;
      low <= 1'b0;
    end else if (iord_n && iowr_n) begin
      if (n == 0) low <= (wt != 0);
    end else begin
      n <= n + 1;
      low <= (n + 1 < wt);
    end
  end
endmodule // pio_card_model
`default_nettype wire

// File: test/pio_host_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pio_host_tb_top;
  import pio_host_pkg::*;
  logic clk = 0, arst_n = 0, req_valid = 0, req_write = 0, req_reg8 = 0;
  logic req_ready, rsp_valid, rsp_wide, rsp_waited, iord_n, iowr_n;
  logic data_oe, iordy, iocs16_n;
  logic [1:0] req_cs = '0, cs_n;
  logic [2:0] req_addr = '0, addr;
  logic [15:0] req_wdata = '0, rsp_rdata, data_o, data_i;
  logic [7:0] wt = '0;
  mode_t pio_mode = '0;
  int mismatches = 0, n_compared = 0;
  always #4 clk = ~clk;
  pio_host pio_host_i (.*);
  pio_card_model pio_card_model_i (.*);
  // ----
  // checks
  // ----
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input logic w, input logic [1:0] c, input logic [2:0] a,
                     input logic r8, input logic [15:0] d, input mode_t m,
                     input logic [7:0] l);
    int k;
    int mi;
    mi = (m > 3'h4) ? 0 : int'(m);
    wt = l;
    {req_write, req_cs, req_addr, req_reg8, req_wdata, pio_mode} =
      {w, c, a, r8, d, m};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    k = 1;
    while (rsp_valid !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    chk("done", rsp_valid, 1);
    chk("length", 16'(k >= (T0_NS[mi] + 7) / 8 && k >= l), 1);
    chk("waited", rsp_waited, 16'(l * CLK_PERIOD_NS > TA_NS));
    chk("wide", rsp_wide, 16'(mi < 3));
    if (!w) chk("rdata", rsp_rdata & (r8 ? 16'h00ff : 16'hffff), d);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_modes();
    for (int m = 0; m < 5; m++) begin
      cyc(1, 2'h1, 3'(m), 0, 16'h5a00 + 16'(m), mode_t'(m), 8'h00);
      cyc(0, 2'h1, 3'(m), 0, 16'h5a00 + 16'(m), mode_t'(m), 8'h00);
    end
  endtask
  task automatic t_select();
    repeat (80) @(negedge clk);
    cyc(1, 2'h1, 3'h7, 1, 16'h00a5, 3'h5, 8'h00);
    cyc(1, 2'h2, 3'h7, 1, 16'h003c, 3'h0, 8'h00);
    cyc(0, 2'h1, 3'h7, 1, 16'h00a5, 3'h0, 8'h00);
    cyc(0, 2'h2, 3'h7, 1, 16'h003c, 3'h0, 8'h00);
  endtask
  task automatic t_ready();
    repeat (80) @(negedge clk);
    cyc(1, 2'h1, 3'h2, 0, 16'hc3e1, 3'h2, 8'h00);
    cyc(0, 2'h1, 3'h2, 0, 16'hc3e1, 3'h2, 8'h01);
    cyc(0, 2'h1, 3'h2, 0, 16'hc3e1, 3'h2, 8'h04);
    cyc(0, 2'h1, 3'h2, 0, 16'hc3e1, 3'h2, 8'h05);
    cyc(0, 2'h1, 3'h2, 0, 16'hc3e1, 3'h2, 8'h3c);
    cyc(1, 2'h1, 3'h3, 0, 16'h1e3c, 3'h4, 8'h96);
    cyc(0, 2'h1, 3'h3, 0, 16'h1e3c, 3'h4, 8'h08);
  endtask
  initial begin
    #200us;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    t_modes();
    t_select();
    t_ready();
    test_done();
  end
endmodule // pio_host_tb_top
`default_nettype wire
